/* File: hdl/adc_conversion_sequencer.sv */
// Digital control of a four-input 10-bit successive approximation converter
// Assumes a plain register port on mclk_in and an external analog front end
//
// What this block and the software driving it do
// (RULE1) Standby stops all conversion activity.
// (RULE2) Mode bit 7 run bit gates operation; clearing stops the converter.
// (RULE3) Result read colliding with result load returns old value; load follows.
// (RULE4) Mode or channel write at conversion end wins; no load, no interrupt.
// (RULE5) Rewriting channel select never clears the done flag.
// (RULE6) Old-channel conversion may finish just before the channel rewrite.
// (RULE7) Software clears the done flag before restarting stopped conversions.
// (RULE8) First result suspect if run set within 1 us of power, or unpowered.
// (RULE9) Software polls the end request and discards the first result.
// (RULE10) Mode or channel writes may leave the result undefined.
// (RULE11) Software reads the result before writing mode or channel.
// (RULE12) Conversion interval runs from sampling start to result, sampling included.
// (RULE13) Software avoids the shared digital port while converting.
// (RULE14) A 10-bit result is delivered for the selected one of four inputs.
// (RULE15) After each completion conversion restarts on the selected channel.
// (RULE16) Mode, channel or threshold writes abort and restart a conversion.
// (RULE17) Clearing the run bit mid-conversion stops at once, result undefined.
// (RULE18) Threshold mode compares upper 8 bits: at least (sense 0) or below (sense 1).
// (RULE19) Each end request sets a done flag held until software clears it.
// (RULE20) Reset returns registers to defaults with conversion stopped.
//
// Strobed register access and the register addresses were left to the implementer.
`include "adc_seq_defs.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 16,
  parameter int BIT_CYCLES = 4
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [`ADC_ADDR_W-1:0] addr_in,
  input wire logic [`ADC_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic standby_in,
  input wire logic comp_in,
  output logic [`ADC_DATA_W-1:0] rdata_out,
  output logic [1:0] channel_out,
  output logic sample_out,
  output logic [9:0] dac_code_out,
  output logic comp_power_out,
  output logic conversion_end_irq_out
);

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [`ADC_ADDR_W-1:0] a,
                               input logic [`ADC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic thr_pass(input logic [9:0] code,
                                    input thr_cfg_t cfg,
                                    input logic [7:0] limit);
    if (!cfg.enable) begin
      thr_pass = 1'b1;
    end else if (!cfg.sense) begin
      thr_pass = (code[9:2] >= limit);
    end else begin
      thr_pass = (code[9:2] < limit);
    end
  endfunction

  // ==========================================================
  // Declarations
  mode_cfg_t converter_mode_reg, converter_mode_next;
  logic [1:0] channel_select_reg, channel_select_next;
  logic [9:0] conversion_result_reg, conversion_result_next;
  thr_cfg_t threshold_mode_reg, threshold_mode_next;
  logic [7:0] threshold_value_reg, threshold_value_next;
  logic [11:0] conv_time_reg, conv_time_next;
  logic conversion_done_flag_reg, conversion_done_flag_next;
  logic suspect_reg, suspect_next;
  logic first_pending_reg, first_pending_next;
  logic [`WARMUP_W-1:0] warm_reg, warm_next;
  seq_state_t seq_reg, seq_next;
  logic [`ADC_DATA_W-1:0] rdata_next;
  logic irq_next;
  logic comp_meta_reg, comp_sync_reg;
  logic start_pulse, abort_pulse;
  logic eng_sample, eng_done;
  logic [9:0] eng_code;
  conv_out_t eng_result;
  logic wr_mode, wr_chan, wr_thr_mode, wr_thr_value, wr_status;
  logic mode_chan_write, restart_write, active, warm_done, store;

  // ==========================================================
  // Comparator level crossing from the analog domain
  // Two flops guard against metastability; the engine
  // sees each decision two cycles late, so bit windows
  // need at least three cycles for a settled answer
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_in;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ==========================================================
  // Write decode and run condition
  // Any write to a setup register counts as a restart,
  // even one that stores the value already held
  // Standby and a cleared run bit both drop the engine
  always_comb begin
    wr_mode = wr_in && hit(addr_in, `OFS_MODE);
    wr_chan = wr_in && hit(addr_in, `OFS_CHAN);
    wr_thr_mode = wr_in && hit(addr_in, `OFS_THR_MODE);
    wr_thr_value = wr_in && hit(addr_in, `OFS_THR_VALUE);
    wr_status = wr_in && hit(addr_in, `OFS_STATUS);
    mode_chan_write = wr_mode || wr_chan;
    restart_write = mode_chan_write || wr_thr_mode || wr_thr_value; // RULE16
    active = converter_mode_reg.run && !standby_in; // RULE1 RULE2
    warm_done = (warm_reg == `WARMUP_W'(`WARMUP_CYC));
  end

  // ==========================================================
  // Control registers written by software
  always_comb begin
    converter_mode_next = converter_mode_reg;
    channel_select_next = channel_select_reg;
    threshold_mode_next = threshold_mode_reg;
    threshold_value_next = threshold_value_reg;
    if (wr_mode) begin
      converter_mode_next.run = wdata_in[`MODE_RUN_BIT];
      converter_mode_next.speed = wdata_in[`MODE_SPEED_MSB:`MODE_SPEED_LSB];
      converter_mode_next.power = wdata_in[`MODE_PWR_BIT];
    end
    if (wr_chan) begin
      channel_select_next = wdata_in[1:0]; // RULE14
    end
    if (wr_thr_mode) begin
      threshold_mode_next.enable = wdata_in[`THR_EN_BIT];
      threshold_mode_next.sense = wdata_in[`THR_SENSE_BIT];
    end
    if (wr_thr_value) begin
      threshold_value_next = wdata_in[7:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      converter_mode_reg <= `MODE_RESET; // RULE20
      channel_select_reg <= `CHAN_RESET;
      threshold_mode_reg <= `THR_MODE_RESET;
      threshold_value_reg <= `THR_VALUE_RESET;
    end else begin
      converter_mode_reg <= converter_mode_next;
      channel_select_reg <= channel_select_next;
      threshold_mode_reg <= threshold_mode_next;
      threshold_value_reg <= threshold_value_next;
    end
  end

  // ==========================================================
  // Comparator warm-up timer and first-result tracking
  // The timer runs only while the comparator is powered
  // and saturates once the warm-up time has passed
  // Starting before then marks the next result suspect
  always_comb begin
    warm_next = warm_reg;
    first_pending_next = first_pending_reg;
    if (!converter_mode_reg.power) begin
      warm_next = '0;
    end else if (!warm_done) begin
      warm_next = warm_reg + `WARMUP_W'(1);
    end
    if (wr_mode && wdata_in[`MODE_RUN_BIT] && !converter_mode_reg.run) begin
      first_pending_next = 1'b1;
    end else if (store) begin
      first_pending_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      warm_reg <= '0;
      first_pending_reg <= 1'b0;
    end else begin
      warm_reg <= warm_next;
      first_pending_reg <= first_pending_next;
    end
  end

  // ==========================================================
  // Sequencer: start, abort and endless restart
  // An abort always passes through idle for at least one cycle,
  // so a restart begins cleanly with a fresh sample
  // The engine clears its trial code on its finishing edge;
  // the sequencer then idles one cycle before sampling again
  always_comb begin
    seq_next = seq_reg;
    start_pulse = 1'b0;
    abort_pulse = 1'b0;
    unique case (seq_reg)
      SEQ_IDLE: begin
        if (active && !restart_write) begin
          start_pulse = 1'b1;
          seq_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (!active) begin
          abort_pulse = 1'b1; // RULE17 RULE1
          seq_next = SEQ_IDLE;
        end else if (restart_write) begin
          abort_pulse = 1'b1; // RULE16 RULE10
          seq_next = SEQ_IDLE;
        end else if (eng_done) begin
          seq_next = SEQ_IDLE; // RULE15
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      seq_reg <= SEQ_IDLE; // RULE20
    end else begin
      seq_reg <= seq_next;
    end
  end

  // ==========================================================
  // Result store, interrupt and status flags
  // A restarting write in the done cycle wins: the
  // finished code is dropped with no request raised
  // Setting the done flag wins over a same-cycle clear,
  // so software never loses an end of conversion
  always_comb begin
    store = eng_done && (seq_reg == SEQ_RUN) && active && !restart_write; // RULE4 RULE6
    conversion_result_next = conversion_result_reg;
    conv_time_next = conv_time_reg;
    suspect_next = suspect_reg;
    irq_next = 1'b0;
    if (store) begin
      conversion_result_next = eng_result.code; // RULE3 RULE14
      conv_time_next = eng_result.interval; // RULE12
      irq_next = thr_pass(eng_result.code, threshold_mode_reg, threshold_value_reg); // RULE18
    end
    if (wr_mode && wdata_in[`MODE_RUN_BIT] && !converter_mode_reg.run) begin
      suspect_next = !(converter_mode_reg.power && warm_done); // RULE8
    end else if (store && !first_pending_reg) begin
      suspect_next = 1'b0;
    end
    conversion_done_flag_next = conversion_done_flag_reg;
    if (wr_status && wdata_in[`STAT_DONE_BIT]) begin
      conversion_done_flag_next = 1'b0;
    end
    if (irq_next) begin
      conversion_done_flag_next = 1'b1; // RULE19 RULE5
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      conversion_result_reg <= `RESULT_RESET; // RULE20
      conv_time_reg <= '0;
      suspect_reg <= 1'b0;
      conversion_done_flag_reg <= 1'b0;
      conversion_end_irq_out <= 1'b0;
    end else begin
      conversion_result_reg <= conversion_result_next;
      conv_time_reg <= conv_time_next;
      suspect_reg <= suspect_next;
      conversion_done_flag_reg <= conversion_done_flag_next;
      conversion_end_irq_out <= irq_next;
    end
  end

  // ==========================================================
  // Read port: data sampled before any same-cycle result load
  // The old result goes out while the new one is loaded
  // on the same edge; the reader sees it a cycle later
  always_comb begin
    rdata_next = '0;
    if (rd_in) begin
      unique case (addr_in)
        `OFS_MODE: begin
          rdata_next[`MODE_RUN_BIT] = converter_mode_reg.run;
          rdata_next[`MODE_SPEED_MSB:`MODE_SPEED_LSB] = converter_mode_reg.speed;
          rdata_next[`MODE_PWR_BIT] = converter_mode_reg.power;
        end
        `OFS_CHAN: rdata_next[1:0] = channel_select_reg;
        `OFS_RESULT: rdata_next[9:0] = conversion_result_reg; // RULE3
        `OFS_THR_MODE: begin
          rdata_next[`THR_EN_BIT] = threshold_mode_reg.enable;
          rdata_next[`THR_SENSE_BIT] = threshold_mode_reg.sense;
        end
        `OFS_THR_VALUE: rdata_next[7:0] = threshold_value_reg;
        `OFS_STATUS: begin
          rdata_next[`STAT_DONE_BIT] = conversion_done_flag_reg;
          rdata_next[`STAT_SUSPECT_BIT] = suspect_reg;
          rdata_next[`STAT_BUSY_BIT] = (seq_reg == SEQ_RUN);
          rdata_next[`STAT_FIRST_BIT] = first_pending_reg;
        end
        `OFS_CONV_TIME: rdata_next[11:0] = conv_time_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rdata_out <= '0;
      channel_out <= `CHAN_RESET;
      comp_power_out <= 1'b0;
    end else begin
      rdata_out <= rdata_next;
      channel_out <= channel_select_next;
      comp_power_out <= converter_mode_next.power;
    end
  end

  // ==========================================================
  // Approximation engine
  // Fed with the synchronised comparator level only
  sar_engine #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .BIT_CYCLES(BIT_CYCLES)
  ) i_sar_engine (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .start_in(start_pulse),
    .abort_in(abort_pulse),
    .comp_in(comp_sync_reg),
    .sample_out(eng_sample),
    .dac_code_out(eng_code),
    .done_out(eng_done),
    .result_out(eng_result)
  );

  // Engine outputs are already flip-flops
  // and pass to the pins without further logic
  always_comb begin
    sample_out = eng_sample;
    dac_code_out = eng_code;
  end

endmodule

/* File: hdl/adc_seq_defs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the sequencer design files
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ==========================================================
// Register bus geometry
`define ADC_ADDR_W 4
`define ADC_DATA_W 16

// ==========================================================
// Register offsets
`define OFS_MODE 4'h0
`define OFS_CHAN 4'h1
`define OFS_RESULT 4'h2
`define OFS_THR_MODE 4'h3
`define OFS_THR_VALUE 4'h4
`define OFS_STATUS 4'h5
`define OFS_CONV_TIME 4'h6

// ==========================================================
// Field positions
`define MODE_RUN_BIT 7
`define MODE_SPEED_MSB 5
`define MODE_SPEED_LSB 1
`define MODE_PWR_BIT 0
`define THR_EN_BIT 7
`define THR_SENSE_BIT 6
`define STAT_DONE_BIT 0
`define STAT_SUSPECT_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_FIRST_BIT 3

// ==========================================================
// Reset values
`define MODE_RESET 7'h00
`define CHAN_RESET 2'h0
`define RESULT_RESET 10'h000
`define THR_MODE_RESET 2'h0
`define THR_VALUE_RESET 8'h00

// ==========================================================
// Timing: comparator warm-up before the first trustworthy result
`define CLK_MHZ 200
`define WARMUP_NS 1000
`define WARMUP_CYC ((`WARMUP_NS * `CLK_MHZ + 999) / 1000)
`define WARMUP_W 8

`endif

/* File: hdl/adc_seq_pkg.sv */
// Types shared by the conversion sequencer and its approximation engine
// Assumes nothing beyond a SystemVerilog compiler
package adc_seq_pkg;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic run;
    logic [4:0] speed;
    logic power;
  } mode_cfg_t;

  typedef struct packed {
    logic enable;
    logic sense;
  } thr_cfg_t;

  typedef struct packed {
    logic [9:0] code;
    logic [11:0] interval;
  } conv_out_t;

  // ==========================================================
  // State enumerations
  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_SETTLE
  } sar_state_t;

endpackage

/* File: hdl/sar_engine.sv */
// Successive approximation engine: sample, then ten trial bits MSB first
// Assumes a synchronised comparator level that is high when input >= trial level
`include "adc_seq_defs.svh"
module sar_engine
  import adc_seq_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 16,
  parameter int BIT_CYCLES = 4
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic comp_in,
  output logic sample_out,
  output logic [9:0] dac_code_out,
  output logic done_out,
  output conv_out_t result_out
);

  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);

  sar_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [11:0] elapsed_reg, elapsed_next;
  logic sample_next, done_next;
  logic [9:0] code_next;
  conv_out_t result_next;

  // ==========================================================
  // Next state: interval counted from first sampling cycle to result
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    elapsed_next = elapsed_reg;
    sample_next = sample_out;
    code_next = dac_code_out;
    done_next = 1'b0;
    result_next = result_out;
    if (abort_in) begin
      state_next = SAR_IDLE;
      sample_next = 1'b0;
      code_next = 10'h000;
    end else begin
      unique case (state_reg)
        SAR_IDLE: begin
          if (start_in) begin
            state_next = SAR_SAMPLE;
            cnt_next = SAMPLE_LAST;
            sample_next = 1'b1;
            code_next = 10'h000;
            elapsed_next = 12'h000; // RULE12
          end
        end
        SAR_SAMPLE: begin
          elapsed_next = elapsed_reg + 12'h001; // RULE12
          if (cnt_reg == 8'h00) begin
            state_next = SAR_SETTLE;
            sample_next = 1'b0;
            bit_next = 4'h9;
            code_next = 10'h200;
            cnt_next = BIT_LAST;
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        SAR_SETTLE: begin
          elapsed_next = elapsed_reg + 12'h001;
          if (cnt_reg == 8'h00) begin
            code_next[bit_reg] = comp_in; // Keep trial bit when input is at or above it
            if (bit_reg == 4'h0) begin
              state_next = SAR_IDLE;
              done_next = 1'b1;
              result_next.code = code_next;
              result_next.interval = elapsed_next; // RULE12
              code_next = 10'h000;
            end else begin
              bit_next = bit_reg - 4'h1;
              code_next[bit_reg - 4'h1] = 1'b1;
              cnt_next = BIT_LAST;
            end
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        default: state_next = SAR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_reg <= SAR_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      elapsed_reg <= 12'h000;
      sample_out <= 1'b0;
      dac_code_out <= 10'h000;
      done_out <= 1'b0;
      result_out <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      elapsed_reg <= elapsed_next;
      sample_out <= sample_next;
      dac_code_out <= code_next;
      done_out <= done_next;
      result_out <= result_next;
    end
  end

endmodule

/* File: tb/adc_seq_checker_sva.sv */
// Port checker for the conversion sequencer
// Assumes one clock and a synchronous active-low reset, bound to the top module
`include "adc_seq_defs.svh"
module adc_seq_checker (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [`ADC_ADDR_W-1:0] addr_in,
  input wire logic [`ADC_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic standby_in,
  input wire logic comp_in,
  input wire logic [`ADC_DATA_W-1:0] rdata_out,
  input wire logic [1:0] channel_out,
  input wire logic sample_out,
  input wire logic [9:0] dac_code_out,
  input wire logic comp_power_out,
  input wire logic conversion_end_irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  // ==========================================================
  // Port relations
  a_reset_quiet:
  assert property (disable iff (1'b0) !resetn_in |=> rdata_out == 16'h0000 &&
    !conversion_end_irq_out && !sample_out && dac_code_out == 10'h000 && !comp_power_out)
  else $error("outputs active after a reset edge");
  a_irq_single_pulse:
  assert property (conversion_end_irq_out |=> (!conversion_end_irq_out) [*8])
  else $error("end request not a lone pulse");
  a_standby_idle:
  assert property (standby_in [*3] |-> !sample_out && dac_code_out == 10'h000)
  else $error("converter active in standby");
  a_run_clear_stop:
  assert property (wr_in && addr_in == `OFS_MODE && !wdata_in[`MODE_RUN_BIT]
    |-> ##2 !sample_out && dac_code_out == 10'h000)
  else $error("conversion continues after run cleared");
  a_power_bit_copy:
  assert property (wr_in && addr_in == `OFS_MODE ##1 !(wr_in && addr_in == `OFS_MODE)
    |=> comp_power_out == $past(wdata_in[`MODE_PWR_BIT], 2))
  else $error("comparator power does not follow mode write");
  a_channel_follow:
  assert property (wr_in && addr_in == `OFS_CHAN |=> channel_out == $past(wdata_in[1:0]))
  else $error("channel output does not follow write");
  a_collide_no_irq:
  assert property (wr_in && (addr_in == `OFS_MODE || addr_in == `OFS_CHAN)
    |=> !conversion_end_irq_out)
  else $error("end request raised beside mode or channel write");
  a_result_width:
  assert property (rd_in && addr_in == `OFS_RESULT |=> rdata_out[15:10] == 6'h00)
  else $error("result wider than ten bits");
endmodule

bind adc_conversion_sequencer adc_seq_checker i_adc_seq_checker (.mclk_in, .resetn_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .standby_in, .comp_in, .rdata_out, .channel_out,
  .sample_out, .dac_code_out, .comp_power_out, .conversion_end_irq_out);

/* File: tb/analog_src_model.sv */
// Model of the four analog sources feeding the converter's comparator
// Assumes the sequencer's channel, sample and trial code outputs on mclk_in
module analog_src_model (
  input wire logic mclk_in,
  input wire logic [39:0] levels_in,
  input wire logic [1:0] channel_in,
  input wire logic sample_in,
  input wire logic power_in,
  input wire logic [9:0] dac_code_in,
  output logic comp_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] held_reg = 10'h000;
  logic flip_reg = 1'b0;

  // Hold the selected input while the sample switch is on
  always_ff @(posedge mclk_in) begin
    if (sample_in) begin
      held_reg <= levels_in[channel_in * 10 +: 10];
    end
    flip_reg <= ~flip_reg;
  end

  // An unpowered comparator gives a meaningless, changing decision
  assign comp_out = power_in ? (held_reg >= dac_code_in) : flip_reg;
endmodule

/* File: tb/test_adc_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
// Assumes the analog source model and the bound port checker
`include "adc_seq_defs.svh"
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SMP = 4;
  localparam int BITC = 3;
  localparam logic [9:0] OLD = 10'h2A5;
  localparam logic [9:0] NEW = 10'h15A;
  logic mclk_in, resetn_in, wr_in, rd_in, standby_in, comp_in;
  logic sample_out, comp_power_out, irq, seen;
  logic [3:0] addr_in;
  logic [15:0] wdata_in, rdata_out, d;
  logic [1:0] channel_out;
  logic [9:0] dac_code_out;
  logic [39:0] levels;
  int miscompares = 0;
  int compares = 0;
  int waited, period;

  // ==========================================================
  // Design and analog sources
  adc_conversion_sequencer #(.SAMPLE_CYCLES(SMP), .BIT_CYCLES(BITC)) i_adc_conversion_sequencer (
    .mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .standby_in, .comp_in,
    .rdata_out, .channel_out, .sample_out, .dac_code_out, .comp_power_out,
    .conversion_end_irq_out(irq));
  analog_src_model i_analog_src_model (.mclk_in, .levels_in(levels), .channel_in(channel_out),
    .sample_in(sample_out), .power_in(comp_power_out), .dac_code_in(dac_code_out),
    .comp_out(comp_in));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  // Wait a bounded number of edges for an end request
  task automatic wait_irq(input int limit);
    seen = 1'b0;
    waited = 0;
    while (seen !== 1'b1 && waited < limit) begin
      @(posedge mclk_in);
      #1;
      seen = irq;
      waited++;
    end
  endtask

  // No conversion activity may show while stopped
  task automatic quiet(input int n);
    logic bad;
    bad = 1'b0;
    repeat (2) @(posedge mclk_in);
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      bad = bad | irq | sample_out | (dac_code_out != 10'h000);
    end
    chk({15'h0000, bad}, 16'h0000, "activity while stopped");
  endtask

  // Read or write exactly at the edge that stores a new result
  task automatic collide(input logic do_write);
    wait_irq(200);
    levels[9:0] = NEW;
    reg_wr(`OFS_STATUS, 16'h0001);
    repeat (period - 4) @(posedge mclk_in);
    if (do_write) begin
      reg_wr(`OFS_CHAN, 16'h0000);
      #1;
      chk({15'h0000, irq}, 16'h0000, "request beside write");
      reg_rd(`OFS_STATUS, d);
      chk(d & 16'h0001, 16'h0000, "done beside write");
      reg_rd(`OFS_RESULT, d);
      chk(d, {6'h00, OLD}, "result beside write");
    end else begin
      reg_rd(`OFS_RESULT, d);
      chk(d, {6'h00, OLD}, "colliding read");
      chk({15'h0000, irq}, 16'h0001, "load beside read");
      reg_rd(`OFS_RESULT, d);
      chk(d, {6'h00, NEW}, "result after read");
    end
  endtask

  task automatic report_and_stop();
    $display("TB: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  initial begin
    #100us;
    miscompares++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    report_and_stop();
  end

  // ==========================================================
  // Test sequence
  initial begin
    {resetn_in, wr_in, rd_in, standby_in} = 4'h0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    levels = {10'h001, 10'h3FF, NEW, OLD};
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      reg_rd(a[3:0], d);
      chk(d, 16'h0000, "reset value");
    end
    reg_wr(`OFS_CHAN, 16'h0002);
    reg_wr(`OFS_MODE, 16'h0081);
    reg_rd(`OFS_STATUS, d);
    chk(d & 16'h000A, 16'h000A, "suspect start");
    wait_irq(200);
    reg_rd(`OFS_STATUS, d);
    chk(d & 16'h000B, 16'h0003, "first result");
    wait_irq(200);
    reg_rd(`OFS_STATUS, d);
    chk(d & 16'h000B, 16'h0001, "second result");
    reg_rd(`OFS_CONV_TIME, d);
    chk(d, 16'(SMP + 10 * BITC), "interval");
    for (int ch = 0; ch < 4; ch++) begin
      reg_wr(`OFS_CHAN, 16'(ch));
      reg_rd(`OFS_STATUS, d);
      chk(d & 16'h0001, 16'h0001, "done over channel write");
      repeat (2) begin
        wait_irq(200);
        reg_rd(`OFS_RESULT, d);
        chk(d, {6'h00, levels[ch * 10 +: 10]}, "channel result");
      end
    end
    reg_wr(`OFS_CHAN, 16'h0000);
    wait_irq(200);
    wait_irq(200);
    period = waited;
    collide(1'b0);
    levels[9:0] = OLD;
    wait_irq(200);
    collide(1'b1);
    wait_irq(3 * period);
    reg_rd(`OFS_RESULT, d);
    chk(d, {6'h00, NEW}, "restart after write");
    for (int i = 0; i < 4; i++) begin
      reg_wr(`OFS_THR_VALUE, (i == 1 || i == 2) ? 16'h0057 : 16'h0056);
      reg_wr(`OFS_THR_MODE, (i < 2) ? 16'h0080 : 16'h00C0);
      wait_irq(3 * period);
      chk({15'h0000, seen}, (i == 0 || i == 2) ? 16'h0001 : 16'h0000, "threshold");
    end
    reg_wr(`OFS_THR_MODE, 16'h0000);
    wait_irq(200);
    reg_wr(`OFS_MODE, 16'h0001);
    quiet(100);
    reg_wr(`OFS_STATUS, 16'h0001);
    reg_wr(`OFS_MODE, 16'h0081);
    wait_irq(200);
    chk({15'h0000, seen}, 16'h0001, "run again");
    @(posedge mclk_in);
    standby_in <= 1'b1;
    quiet(100);
    @(posedge mclk_in);
    standby_in <= 1'b0;
    wait_irq(200);
    chk({15'h0000, seen}, 16'h0001, "after standby");
    report_and_stop();
  end
endmodule
